/* design/fepm_consts.vh */
// shared constants of the fifo event performance monitor
`ifndef FEPM_CONSTS_VH
`define FEPM_CONSTS_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define FEPM_STATUS_ADDR   12'h500
`define FEPM_OVF_ADDR      12'h504
`define FEPM_UNF_ADDR      12'h508
`define FEPM_SEL1_ADDR     12'h50C
`define FEPM_SEL2_ADDR     12'h510
`define FEPM_TRIG_ADDR     12'h514
`define FEPM_IRQ_STAT_ADDR 12'h518
`define FEPM_IRQ_MASK_ADDR 12'h51C
// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define FEPM_TALLY_W       16
`define FEPM_NUM_CNT       4
`define FEPM_SEEN_LSB      2
`define FEPM_TRIG_BIT      0
`define FEPM_IRQ_W         5
`define FEPM_IRQ_LATCH_BIT 0
`define FEPM_IRQ_SAT_LSB   1
// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define FEPM_TALLY_RST     16'h0000
`define FEPM_IRQ_RST       5'h00
`define FEPM_RESP_OKAY     2'h0
`define FEPM_RESP_DECERR   2'h3
`endif

/* design/fepm_axil_slave.v */
// axi4-lite slave handshake for the fifo event performance monitor
`timescale 1ns/100ps
`include "fepm_consts.vh"
module fepm_axil_slave #(
    parameter ADDR_W = 12
) (
    input  wire              sys_clk_i,
    input  wire              rst_n_i,
    input  wire [ADDR_W-1:0] s_axil_awaddr_i,
    input  wire              s_axil_awvalid_i,
    output wire              s_axil_awready_o,
    input  wire [31:0]       s_axil_wdata_i,
    input  wire [3:0]        s_axil_wstrb_i,
    input  wire              s_axil_wvalid_i,
    output wire              s_axil_wready_o,
    output reg  [1:0]        s_axil_bresp_o,
    output reg               s_axil_bvalid_o,
    input  wire              s_axil_bready_i,
    input  wire              s_axil_arvalid_i,
    output wire              s_axil_arready_o,
    output reg  [31:0]       s_axil_rdata_o,
    output reg  [1:0]        s_axil_rresp_o,
    output reg               s_axil_rvalid_o,
    input  wire              s_axil_rready_i,
    input  wire [31:0]       rd_data_i,
    input  wire              rd_err_i,
    input  wire              wr_err_i,
    output wire              wr_en_o,
    output reg  [ADDR_W-1:0] wr_addr_o,
    output reg  [31:0]       wr_data_o,
    output reg  [3:0]        wr_strb_o
);
    reg aw_held;
    reg w_held;
    // address and data may come in either order; both wait here
    assign s_axil_awready_o = !aw_held && !s_axil_bvalid_o;
    assign s_axil_wready_o  = !w_held && !s_axil_bvalid_o;
    assign s_axil_arready_o = !s_axil_rvalid_o;
    assign wr_en_o          = aw_held && w_held && !s_axil_bvalid_o;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            wr_addr_o       <= {ADDR_W{1'b0}};
            wr_data_o       <= 32'h00000000;
            wr_strb_o       <= 4'h0;
            s_axil_bvalid_o <= 1'b0;
            s_axil_bresp_o  <= `FEPM_RESP_OKAY;
            s_axil_rvalid_o <= 1'b0;
            s_axil_rresp_o  <= `FEPM_RESP_OKAY;
            s_axil_rdata_o  <= 32'h00000000;
        end else begin
            if (s_axil_awvalid_i && s_axil_awready_o) begin
                aw_held   <= 1'b1;
                wr_addr_o <= s_axil_awaddr_i;
            end
            if (s_axil_wvalid_i && s_axil_wready_o) begin
                w_held    <= 1'b1;
                wr_data_o <= s_axil_wdata_i;
                wr_strb_o <= s_axil_wstrb_i;
            end
            if (wr_en_o) begin
                aw_held         <= 1'b0;
                w_held          <= 1'b0;
                s_axil_bvalid_o <= 1'b1;
                s_axil_bresp_o  <= wr_err_i ? `FEPM_RESP_DECERR : `FEPM_RESP_OKAY;
            end else if (s_axil_bready_i) begin
                s_axil_bvalid_o <= 1'b0;
            end
            if (s_axil_arvalid_i && s_axil_arready_o) begin
                s_axil_rvalid_o <= 1'b1;
                s_axil_rdata_o  <= rd_data_i;
                s_axil_rresp_o  <= rd_err_i ? `FEPM_RESP_DECERR : `FEPM_RESP_OKAY;
            end else if (s_axil_rready_i) begin
                s_axil_rvalid_o <= 1'b0;
            end
        end
    end
endmodule // fepm_axil_slave

/* design/fepm_event_counter.v */
// one event accumulator with its holding register and seen flag
`timescale 1ns/100ps
`include "fepm_consts.vh"
module fepm_event_counter #(
    parameter W = 16
) (
    input  wire         sys_clk_i,
    input  wire         rst_n_i,
    input  wire         event_i,
    input  wire         latch_i,
    output reg  [W-1:0] tally_o,
    output reg          seen_o,
    output reg          sat_o
);
    reg  [W-1:0] acc;
    wire         acc_full = &acc;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            acc     <= {W{1'b0}};
            tally_o <= {W{1'b0}};
            seen_o  <= 1'b0;
            sat_o   <= 1'b0;
        end else if (latch_i) begin
            // an event in the trigger cycle opens the new interval
            tally_o <= acc;
            acc     <= {{(W-1){1'b0}}, event_i};
            seen_o  <= (acc != {W{1'b0}});
            sat_o   <= 1'b0;
        end else begin
            // saturate rather than wrap, so a big count never reads small
            if (event_i && !acc_full) begin
                acc <= acc + {{(W-1){1'b0}}, 1'b1};
            end
            sat_o <= event_i && acc_full;
        end
    end
endmodule // fepm_event_counter

/* design/fepm_top.v */
// fifo event performance monitor: four latched event tallies on axi4-lite
//
// Functional notes
// - status bit 2 shows overflows in last interval
// - status bit 3 shows underflows in last interval
// - status bit 4 shows selectable-one events seen
// - status bit 5 shows selectable-two events seen
// - overflow tally readable at 0x504
// - underflow tally readable at 0x508
// - selectable-one tally readable at 0x50C
// - trigger copies accumulators and restarts them together
// - writes act on the whole word
// - all byte enables off means no access
// - bits 31 to 16 unused in each register
// - selectable-two tally readable at 0x510, same trigger
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "fepm_consts.vh"
module fepm_top #(
    parameter ADDR_W = 12,
    parameter EVW    = 8,
    parameter W      = 16
) (
    input  wire              sys_clk_i,
    input  wire              rst_n_i,
    input  wire [ADDR_W-1:0] s_axil_awaddr_i,
    input  wire              s_axil_awvalid_i,
    output wire              s_axil_awready_o,
    input  wire [31:0]       s_axil_wdata_i,
    input  wire [3:0]        s_axil_wstrb_i,
    input  wire              s_axil_wvalid_i,
    output wire              s_axil_wready_o,
    output wire [1:0]        s_axil_bresp_o,
    output wire              s_axil_bvalid_o,
    input  wire              s_axil_bready_i,
    input  wire [ADDR_W-1:0] s_axil_araddr_i,
    input  wire              s_axil_arvalid_i,
    output wire              s_axil_arready_o,
    output wire [31:0]       s_axil_rdata_o,
    output wire [1:0]        s_axil_rresp_o,
    output wire              s_axil_rvalid_o,
    input  wire              s_axil_rready_i,
    input  wire              rx_overflow_event_i,
    input  wire              tx_underflow_event_i,
    input  wire [EVW-1:0]    monitor_events_i,
    input  wire [EVW-1:0]    select_one_i,
    input  wire [EVW-1:0]    select_two_i,
    input  wire              accum_trigger_i,
    output reg               overflow_seen_flag_o,
    output reg               underflow_seen_flag_o,
    output reg               selectable_one_seen_flag_o,
    output reg               selectable_two_seen_flag_o,
    output wire              irq_o
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam NC = `FEPM_NUM_CNT;

    wire                 wr_en;
    wire [ADDR_W-1:0]    wr_addr;
    wire [31:0]          wr_data;
    wire [3:0]           wr_strb;
    wire                 wr_any_lane;
    wire                 wr_act;
    wire [ADDR_W-1:0]    wr_word;
    wire [ADDR_W-1:0]    rd_word;
    reg  [31:0]          rd_data;
    reg                  rd_err;
    reg                  wr_err;
    wire                 soft_trig;
    wire                 latch;
    wire [NC-1:0]        cnt_event;
    wire [NC*W-1:0]      tallies;
    wire [NC-1:0]        seen;
    wire [NC-1:0]        sat;
    reg                  latch_done;
    reg  [`FEPM_IRQ_W-1:0] irq_stat;
    reg  [`FEPM_IRQ_W-1:0] irq_mask;
    wire [`FEPM_IRQ_W-1:0] irq_set;
    wire [`FEPM_IRQ_W-1:0] irq_clr;
    wire [`FEPM_IRQ_W-1:0] next_irq_stat;
    wire [31:0]          status_word;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    fepm_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .sys_clk_i        (sys_clk_i),
        .rst_n_i          (rst_n_i),
        .s_axil_awaddr_i  (s_axil_awaddr_i),
        .s_axil_awvalid_i (s_axil_awvalid_i),
        .s_axil_awready_o (s_axil_awready_o),
        .s_axil_wdata_i   (s_axil_wdata_i),
        .s_axil_wstrb_i   (s_axil_wstrb_i),
        .s_axil_wvalid_i  (s_axil_wvalid_i),
        .s_axil_wready_o  (s_axil_wready_o),
        .s_axil_bresp_o   (s_axil_bresp_o),
        .s_axil_bvalid_o  (s_axil_bvalid_o),
        .s_axil_bready_i  (s_axil_bready_i),
        .s_axil_arvalid_i (s_axil_arvalid_i),
        .s_axil_arready_o (s_axil_arready_o),
        .s_axil_rdata_o   (s_axil_rdata_o),
        .s_axil_rresp_o   (s_axil_rresp_o),
        .s_axil_rvalid_o  (s_axil_rvalid_o),
        .s_axil_rready_i  (s_axil_rready_i),
        .rd_data_i        (rd_data),
        .rd_err_i         (rd_err),
        .wr_err_i         (wr_err),
        .wr_en_o          (wr_en),
        .wr_addr_o        (wr_addr),
        .wr_data_o        (wr_data),
        .wr_strb_o        (wr_strb)
    );

    // ----------------------------------------------------------------
    // write qualification
    // ----------------------------------------------------------------
    // byte lanes are not selectable: any lane on means the full word
    assign wr_any_lane = |wr_strb;
    assign wr_act      = wr_en && wr_any_lane;
    assign wr_word     = {wr_addr[ADDR_W-1:2], 2'b00};
    assign rd_word     = {s_axil_araddr_i[ADDR_W-1:2], 2'b00};

    // unmapped write addresses answer decerr, tally writes are dropped
    always @* begin
        case (wr_word)
            `FEPM_STATUS_ADDR,
            `FEPM_OVF_ADDR,
            `FEPM_UNF_ADDR,
            `FEPM_SEL1_ADDR,
            `FEPM_SEL2_ADDR,
            `FEPM_TRIG_ADDR,
            `FEPM_IRQ_STAT_ADDR,
            `FEPM_IRQ_MASK_ADDR: begin
                wr_err = 1'b0;
            end
            default: begin
                wr_err = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // accumulation trigger
    // ----------------------------------------------------------------
    assign soft_trig = wr_act && (wr_word == `FEPM_TRIG_ADDR) && wr_data[`FEPM_TRIG_BIT];
    // external and software triggers share one latch edge
    assign latch     = accum_trigger_i || soft_trig;

    // ----------------------------------------------------------------
    // event selection
    // ----------------------------------------------------------------
    // several selected sources in one cycle count as a single event
    assign cnt_event[0] = rx_overflow_event_i;
    assign cnt_event[1] = tx_underflow_event_i;
    assign cnt_event[2] = |(monitor_events_i & select_one_i);
    assign cnt_event[3] = |(monitor_events_i & select_two_i);

    // ----------------------------------------------------------------
    // accumulators
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi = gi + 1) begin : g_cnt
            fepm_event_counter #(
                .W (W)
            ) u_cnt (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .event_i   (cnt_event[gi]),
                .latch_i   (latch),
                .tally_o   (tallies[gi*W +: W]),
                .seen_o    (seen[gi]),
                .sat_o     (sat[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // seen flags
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            overflow_seen_flag_o       <= 1'b0;
            underflow_seen_flag_o      <= 1'b0;
            selectable_one_seen_flag_o <= 1'b0;
            selectable_two_seen_flag_o <= 1'b0;
            latch_done                 <= 1'b0;
        end else begin
            // one cycle behind the counters and the readable status, which shows seen directly
            overflow_seen_flag_o       <= seen[0];
            underflow_seen_flag_o      <= seen[1];
            selectable_one_seen_flag_o <= seen[2];
            selectable_two_seen_flag_o <= seen[3];
            latch_done                 <= latch;
        end
    end

    assign status_word = {{(32-`FEPM_SEEN_LSB-NC){1'b0}}, seen, {`FEPM_SEEN_LSB{1'b0}}};

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign irq_set = {sat, latch_done};
    assign irq_clr = (wr_act && (wr_word == `FEPM_IRQ_STAT_ADDR)) ? wr_data[`FEPM_IRQ_W-1:0]
                                                                  : `FEPM_IRQ_RST;
    // a new event beats a clear landing in the same cycle
    assign next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    assign irq_o         = |(irq_stat & irq_mask);

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= `FEPM_IRQ_RST;
            irq_mask <= `FEPM_IRQ_RST;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_act && (wr_word == `FEPM_IRQ_MASK_ADDR)) begin
                irq_mask <= wr_data[`FEPM_IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    // unused upper halves read as zero
    always @* begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        case (rd_word)
            `FEPM_STATUS_ADDR: begin
                rd_data = status_word;
            end
            `FEPM_OVF_ADDR: begin
                rd_data = {{(32-W){1'b0}}, tallies[0*W +: W]};
            end
            `FEPM_UNF_ADDR: begin
                rd_data = {{(32-W){1'b0}}, tallies[1*W +: W]};
            end
            `FEPM_SEL1_ADDR: begin
                rd_data = {{(32-W){1'b0}}, tallies[2*W +: W]};
            end
            `FEPM_SEL2_ADDR: begin
                rd_data = {{(32-W){1'b0}}, tallies[3*W +: W]};
            end
            `FEPM_TRIG_ADDR: begin
                rd_data = 32'h00000000;
            end
            `FEPM_IRQ_STAT_ADDR: begin
                rd_data = {{(32-`FEPM_IRQ_W){1'b0}}, irq_stat};
            end
            `FEPM_IRQ_MASK_ADDR: begin
                rd_data = {{(32-`FEPM_IRQ_W){1'b0}}, irq_mask};
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end
endmodule // fepm_top

/* testbench/fepm_props.sv */
// assertions for the fifo event performance monitor
`timescale 1ns/100ps
module fepm_props #(
    parameter ADDR_W = 12,
    parameter EVW    = 8,
    parameter W      = 16
) (
    input logic           sys_clk_i,
    input logic           rst_n_i,
    input logic           rx_overflow_event_i,
    input logic           tx_underflow_event_i,
    input logic [EVW-1:0] monitor_events_i,
    input logic [EVW-1:0] select_one_i,
    input logic [EVW-1:0] select_two_i,
    input logic           accum_trigger_i,
    input logic           overflow_seen_flag_o,
    input logic           underflow_seen_flag_o,
    input logic           selectable_one_seen_flag_o,
    input logic           selectable_two_seen_flag_o,
    input logic [31:0]    s_axil_rdata_o,
    input logic           s_axil_rvalid_o,
    input logic           s_axil_bvalid_o,
    input logic           s_axil_bready_i,
    input logic           irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // several selected sources in one cycle are one event
    wire hit_one = |(monitor_events_i & select_one_i);
    wire hit_two = |(monitor_events_i & select_two_i);
    // ----------------------------------------
    // seen flags follow the latched interval
    // ----------------------------------------
    ovf_seen_a: assert property (rx_overflow_event_i ##1 accum_trigger_i |-> ##2 overflow_seen_flag_o)
        else $error("overflow flag stayed low");
    ovf_quiet_a: assert property ((accum_trigger_i && !rx_overflow_event_i) ##1 accum_trigger_i
        |-> ##2 !overflow_seen_flag_o) else $error("overflow flag stayed high");
    unf_seen_a: assert property (tx_underflow_event_i ##1 accum_trigger_i |-> ##2 underflow_seen_flag_o)
        else $error("underflow flag stayed low");
    unf_quiet_a: assert property ((accum_trigger_i && !tx_underflow_event_i) ##1 accum_trigger_i
        |-> ##2 !underflow_seen_flag_o) else $error("underflow flag stayed high");
    one_seen_a: assert property (hit_one ##1 accum_trigger_i |-> ##2 selectable_one_seen_flag_o)
        else $error("first selectable flag stayed low");
    one_quiet_a: assert property ((accum_trigger_i && !hit_one) ##1 accum_trigger_i
        |-> ##2 !selectable_one_seen_flag_o) else $error("first selectable flag stayed high");
    two_seen_a: assert property (hit_two ##1 accum_trigger_i |-> ##2 selectable_two_seen_flag_o)
        else $error("second selectable flag stayed low");
    two_quiet_a: assert property ((accum_trigger_i && !hit_two) ##1 accum_trigger_i
        |-> ##2 !selectable_two_seen_flag_o) else $error("second selectable flag stayed high");
    upper_zero_a: assert property (s_axil_rvalid_o |-> s_axil_rdata_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    cover property (accum_trigger_i ##1 accum_trigger_i);
    cover property (irq_o);
    cover property (s_axil_bvalid_o && s_axil_bready_i);
endmodule // fepm_props

bind fepm_top fepm_props #(.ADDR_W(ADDR_W), .EVW(EVW), .W(W)) u_props (.*);

/* testbench/tb.sv */
// self-checking bench of the fifo event performance monitor
`timescale 1ns/100ps
`include "fepm_consts.vh"
module tb;
    localparam logic [1:0] OKR = `FEPM_RESP_OKAY;
    localparam logic [1:0] DER = `FEPM_RESP_DECERR;
    logic        sys_clk_i = 1'h0, rst_n_i = 1'h0, accum_trigger_i = 1'h0;
    logic [11:0] s_axil_awaddr_i = 12'h000, s_axil_araddr_i = 12'h000;
    logic [31:0] s_axil_wdata_i = 32'h0, s_axil_rdata_o;
    logic [3:0]  s_axil_wstrb_i = 4'h0;
    logic [1:0]  s_axil_bresp_o, s_axil_rresp_o;
    logic [7:0]  monitor_events_i = 8'h00, select_one_i = 8'h03, select_two_i = 8'h30;
    logic        s_axil_awvalid_i = 1'h0, s_axil_wvalid_i = 1'h0, s_axil_bready_i = 1'h0;
    logic        s_axil_arvalid_i = 1'h0, s_axil_rready_i = 1'h0;
    logic        rx_overflow_event_i = 1'h0, tx_underflow_event_i = 1'h0;
    logic        s_axil_awready_o, s_axil_wready_o, s_axil_bvalid_o, s_axil_arready_o, s_axil_rvalid_o, irq_o;
    logic        overflow_seen_flag_o, underflow_seen_flag_o, selectable_one_seen_flag_o, selectable_two_seen_flag_o;
    int          n_fail = 0, tests_run = 0;

    always #5 sys_clk_i = ~sys_clk_i;
    fepm_top DUT (.*);

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic final_report;
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // bounded waits: a missing answer shows up as a failed compare
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int t;
        t = 0;
        @(posedge sys_clk_i);
        s_axil_awaddr_i  <= a;
        s_axil_wdata_i   <= d;
        s_axil_wstrb_i   <= s;
        s_axil_awvalid_i <= 1'h1;
        s_axil_wvalid_i  <= 1'h1;
        s_axil_bready_i  <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            t++;
            if (s_axil_awready_o) s_axil_awvalid_i <= 1'h0;
            if (s_axil_wready_o) s_axil_wvalid_i <= 1'h0;
        end while (!s_axil_bvalid_o && t < 40);
        s_axil_bready_i <= 1'h0;
        chk({s_axil_bvalid_o, s_axil_bresp_o}, {1'h1, r}, "write answer");
    endtask

    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        int t;
        t = 0;
        @(posedge sys_clk_i);
        s_axil_araddr_i  <= a;
        s_axil_arvalid_i <= 1'h1;
        s_axil_rready_i  <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            t++;
            if (s_axil_arready_o) s_axil_arvalid_i <= 1'h0;
        end while (!s_axil_rvalid_o && t < 40);
        s_axil_rready_i <= 1'h0;
        chk({s_axil_rvalid_o, s_axil_rresp_o, s_axil_rdata_o}, {1'h1, r, e}, "read answer");
    endtask

    // all sources end on the last cycle so a trigger follows at once; bit 7 is never selected
    task automatic burst(input int nov, input int nun, input int n1, input int n2);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            rx_overflow_event_i  <= (i >= 8 - nov);
            tx_underflow_event_i <= (i >= 8 - nun);
            monitor_events_i     <= 8'h80 | (i >= 8 - n1 ? 8'h03 : 8'h00) | (i >= 8 - n2 ? 8'h30 : 8'h00);
        end
    endtask

    task automatic trig(input logic ev, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            accum_trigger_i      <= 1'h1;
            rx_overflow_event_i  <= ev;
            tx_underflow_event_i <= 1'h0;
            monitor_events_i     <= 8'h80;
        end
        @(posedge sys_clk_i);
        accum_trigger_i     <= 1'h0;
        rx_overflow_event_i <= 1'h0;
    endtask

    task automatic tallies(input logic [15:0] ov, input logic [15:0] un, input logic [15:0] c1, input logic [15:0] c2);
        axr(`FEPM_OVF_ADDR, {16'h0, ov}, OKR);
        axr(`FEPM_UNF_ADDR, {16'h0, un}, OKR);
        axr(`FEPM_SEL1_ADDR, {16'h0, c1}, OKR);
        axr(`FEPM_SEL2_ADDR, {16'h0, c2}, OKR);
        axr(`FEPM_STATUS_ADDR, {26'h0, c2 != 0, c1 != 0, un != 0, ov != 0, 2'h0}, OKR);
        chk({selectable_two_seen_flag_o, selectable_one_seen_flag_o, underflow_seen_flag_o, overflow_seen_flag_o},
            {c2 != 0, c1 != 0, un != 0, ov != 0}, "seen flags");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        tallies(16'h0, 16'h0, 16'h0, 16'h0);
        axr(`FEPM_IRQ_MASK_ADDR, 32'h0, OKR);
        axr(12'h520, 32'h0, DER);
        axw(12'h600, 32'h1, 4'hF, DER);
    endtask

    task automatic t_counts;
        burst(3, 5, 2, 7);
        trig(1'h0, 1);
        tallies(16'h3, 16'h5, 16'h2, 16'h7);
        burst(0, 4, 0, 1);
        trig(1'h0, 1);
        tallies(16'h0, 16'h4, 16'h0, 16'h1);
        axw(`FEPM_UNF_ADDR, 32'hFFFF, 4'hF, OKR);
        tallies(16'h0, 16'h4, 16'h0, 16'h1);
    endtask

    // an event on the trigger edge belongs to the next interval
    task automatic t_carry;
        burst(2, 0, 0, 0);
        trig(1'h1, 1);
        tallies(16'h2, 16'h0, 16'h0, 16'h0);
        trig(1'h0, 1);
        tallies(16'h1, 16'h0, 16'h0, 16'h0);
        trig(1'h0, 2);
        tallies(16'h0, 16'h0, 16'h0, 16'h0);
    endtask

    task automatic t_strobes;
        burst(3, 0, 0, 0);
        trig(1'h0, 1);
        axw(`FEPM_TRIG_ADDR, 32'h1, 4'h0, OKR);
        tallies(16'h3, 16'h0, 16'h0, 16'h0);
        axw(`FEPM_TRIG_ADDR, 32'h1, 4'h2, OKR);
        tallies(16'h0, 16'h0, 16'h0, 16'h0);
        axr(`FEPM_TRIG_ADDR, 32'h0, OKR);
    endtask

    // earlier triggers left the latch-done bit set: clear it so the raise is real
    task automatic t_irq;
        axw(`FEPM_IRQ_STAT_ADDR, 32'h1F, 4'hF, OKR);
        axw(`FEPM_IRQ_MASK_ADDR, 32'h1, 4'hF, OKR);
        chk(irq_o, 1'h0, "irq idle before trigger");
        trig(1'h0, 1);
        repeat (3) @(posedge sys_clk_i);
        chk(irq_o, 1'h1, "irq raised");
        axr(`FEPM_IRQ_STAT_ADDR, 32'h1, OKR);
        axw(`FEPM_IRQ_MASK_ADDR, 32'h0, 4'hF, OKR);
        chk(irq_o, 1'h0, "irq masked");
        axw(`FEPM_IRQ_STAT_ADDR, 32'h1, 4'hF, OKR);
        axw(`FEPM_IRQ_MASK_ADDR, 32'h1, 4'hF, OKR);
        chk(irq_o, 1'h0, "irq cleared");
        axr(`FEPM_IRQ_STAT_ADDR, 32'h0, OKR);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        t_reset();
        t_counts();
        t_carry();
        t_strobes();
        t_irq();
        final_report();
    end

    // the whole run needs well under two thousand cycles
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule // tb
